// ==== bfs_cfg.svh ====
// Timing counts and strap field positions for the fault supervisor
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// Clock period
`define BFS_CLK_NS        10
// Undervoltage delay filter, 1 ms
`define BFS_UVP_DLY_NS    1000000
`define BFS_UVP_DLY_CYC   (`BFS_UVP_DLY_NS / `BFS_CLK_NS)
// Shortest soft-start step, 1 ms, doubled per step code
`define BFS_SS_BASE_NS    1000000
`define BFS_SS_BASE_CYC   (`BFS_SS_BASE_NS / `BFS_CLK_NS)
// Hiccup blanking unit of 1 ms and multipliers per soft-start code
`define BFS_HIC_UNIT_NS   1000000
`define BFS_HIC_UNIT_CYC  (`BFS_HIC_UNIT_NS / `BFS_CLK_NS)
`define BFS_HIC_MUL_1MS   24'h000010
`define BFS_HIC_MUL_2MS   24'h000018
`define BFS_HIC_MUL_4MS   24'h000026
`define BFS_HIC_MUL_8MS   24'h000043
// Minimum on-time during discharge, least time so rounded up
`define BFS_MIN_ON_NS     60
`define BFS_MIN_ON_CYC    ((`BFS_MIN_ON_NS + `BFS_CLK_NS - 1) / `BFS_CLK_NS)

// Topology strap fields
`define BFS_TOPO_RAMP     4
`define BFS_TOPO_EXTREF   3
`define BFS_TOPO_EXTSS    2
// Reference select strap field
`define BFS_REF_POLICY    0
// Frequency strap fields
`define BFS_FREQ_FORCED_CONTINUOUS_CONDUCTION     0

// Reset values
`define BFS_CNT_RST       24'h000000
`endif

// ==== bfs_pkg.sv ====
// Types shared by the fault supervisor modules
package bfs_pkg;

   typedef logic [23:0] bfs_cnt_t;

   typedef enum logic [2:0] {
      BFS_OFF      = 3'b000,
      BFS_SOFT     = 3'b001,
      BFS_RUN      = 3'b010,
      BFS_DISCH    = 3'b011,
      BFS_LATCH    = 3'b100,
      BFS_LATCH_LS = 3'b101,
      BFS_HICCUP   = 3'b110
   } bfs_state_e;

   typedef struct packed {
      bfs_state_e st;
      bfs_cnt_t   cnt;
      bfs_cnt_t   uvc;
      logic       hs;
      logic       ls;
      logic       ovfix;
      logic       flt;
      logic       ssact;
      logic       ext_ref;
      logic       ext_ss;
   } bfs_sup_s;

   typedef struct packed {
      logic       armed;
      logic       valid;
      logic [4:0] freq;
      logic [4:0] refs;
      logic [4:0] topo;
   } bfs_strap_s;

endpackage

// ==== bfs_sync.sv ====
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module bfs_sync import bfs_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } bfs_sync_s;

   bfs_sync_s r_reg;
   bfs_sync_s r_next;

   // First stage feeds only the second stage
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   // Register both stages
   always_ff @(posedge clock) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;
endmodule

// ==== bfs_strap.sv ====
// Strap capture: samples the three strap codes once per power-up
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_strap import bfs_pkg::*; (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       bias_ok,
   input  wire logic       bias_collapse,
   input  wire logic [4:0] freq_in,
   input  wire logic [4:0] ref_in,
   input  wire logic [4:0] topo_in,
   output logic            valid,
   output logic      [4:0] frequency_strap,
   output logic      [4:0] reference_select_strap,
   output logic      [4:0] topology_strap
);
   bfs_strap_s r_reg;
   bfs_strap_s r_next;

   // Arm on collapse, capture once bias is good, then hold
   always_comb begin
      r_next = r_reg;
      if (bias_collapse) begin
         r_next.armed = 1'b1;
         r_next.valid = 1'b0;
      end else if (r_reg.armed && bias_ok) begin
         r_next.armed = 1'b0;
         r_next.valid = 1'b1;
         r_next.freq  = freq_in;
         r_next.refs  = ref_in;
         r_next.topo  = topo_in;
      end
   end

   // First power-up after reset counts as a fresh detection
   always_ff @(posedge clock) begin
      if (rst) begin
         r_reg <= '{armed: 1'b1, valid: 1'b0, freq: 5'h00, refs: 5'h00, topo: 5'h00};
      end else begin
         r_reg <= r_next;
      end
   end

   assign valid                  = r_reg.valid;
   assign frequency_strap        = r_reg.freq;
   assign reference_select_strap = r_reg.refs;
   assign topology_strap         = r_reg.topo;
endmodule

// ==== bfs_supervisor.sv ====
// Fault and enable supervisor for a synchronous step-down converter
`timescale 1ns/1ps
`include "bfs_cfg.svh"
// Functional notes
// - Bias supply below on-threshold keeps the converter off, enable ignored.
// - Lockout never latches; enable handling resumes once bias recovers.
// - Strap detection starts only with the bias supply above threshold.
// - Straps sampled once after a bias collapse, then latched.
// - Valley over-limit holds the off state cycle by cycle.
// - Positive and negative current limits, negative used during discharge.
// - Feedback under 68% for 1 ms in run turns both drivers off; latched only with policy bit one, else hiccup.
// - Undervoltage guard armed only after soft-start completes.
// - Feedback over 120% turns high side off, low side on.
// - At negative limit: low side off, high side on for minimum on-time.
// - Discharge ends after 1 ms undervoltage; low side latched on in internal mode or with policy bit one.
// - Latched faults clear only by bias cycling or enable toggling.
// - Topology strap selects external reference or external soft-start.
// - External reference uses fixed 1.5 V overvoltage level during startup.
// - Discharge end: internal mode latches, external modes follow policy bit.
// - Over-temperature shuts off and restarts on cooling, no latch.
// - Topology ramp bit clear disables the internal ramp.
// - Two frequency strap bits fine-tune ramp amplitude.
// - Frequency strap supplies frequency, ramp setting and conduction mode.
// - Policy bit one latches off, zero selects hiccup restart except at discharge end in internal mode, which latches.
// - Two topology bits set soft-start length and hiccup blanking length.
module bfs_supervisor import bfs_pkg::*; #(
   parameter int UV_CYC     = `BFS_UVP_DLY_CYC,
   parameter int SS_CYC     = `BFS_SS_BASE_CYC,
   parameter int HIC_CYC    = `BFS_HIC_UNIT_CYC,
   parameter int MIN_ON_CYC = `BFS_MIN_ON_CYC
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       supply_lockout,
   input  wire logic       bias_collapse,
   input  wire logic       enable_threshold_input,
   input  wire logic       uv_cmp,
   input  wire logic       ov_cmp,
   input  wire logic       valley_over_limit,
   input  wire logic       neg_limit,
   input  wire logic       over_temp,
   input  wire logic       on_request,
   input  wire logic       ext_ss_done,
   input  wire logic [4:0] freq_strap_pin,
   input  wire logic [4:0] ref_strap_pin,
   input  wire logic [4:0] topo_strap_pin,
   output logic            hs_enable,
   output logic            ls_enable,
   output logic            fault_latched,
   output logic            soft_start_active,
   output logic            ovp_fixed_threshold,
   output logic            use_ext_reference,
   output logic            ext_soft_start,
   output logic            ramp_enable,
   output logic      [1:0] ramp_scale_bits,
   output logic      [1:0] freq_select,
   output logic            forced_continuous_conduction,
   output logic            fault_policy_bit,
   output logic      [1:0] soft_start_select,
   output logic            straps_valid
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and strap capture
   logic [24:0] pins_s;
   logic        bias_ok_s;
   logic        collapse_s;
   logic        en_s;
   logic        uv_s;
   logic        ov_s;
   logic        valley_s;
   logic        neg_s;
   logic        ot_s;
   logic        onreq_s;
   logic        extss_s;
   logic [4:0]  freq_q;
   logic [4:0]  ref_q;
   logic [4:0]  topo_q;

   bfs_sync #(.W(25)) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({topo_strap_pin, ref_strap_pin, freq_strap_pin, ext_ss_done,
                on_request, over_temp, neg_limit, valley_over_limit, ov_cmp,
                uv_cmp, enable_threshold_input, bias_collapse, ~supply_lockout}),
      .q     (pins_s)
   );

   assign bias_ok_s  = pins_s[0];
   assign collapse_s = pins_s[1];
   assign en_s       = pins_s[2];
   assign uv_s       = pins_s[3];
   assign ov_s       = pins_s[4];
   assign valley_s   = pins_s[5];
   assign neg_s      = pins_s[6];
   assign ot_s       = pins_s[7];
   assign onreq_s    = pins_s[8];
   assign extss_s    = pins_s[9];

   // Capture only while bias is good, hold until the next collapse
   bfs_strap u_strap (
      .clock                  (clock),
      .rst                    (rst),
      .bias_ok                (bias_ok_s),
      .bias_collapse          (collapse_s),
      .freq_in                (pins_s[14:10]),
      .ref_in                 (pins_s[19:15]),
      .topo_in                (pins_s[24:20]),
      .valid                  (straps_valid),
      .frequency_strap        (freq_q),
      .reference_select_strap (ref_q),
      .topology_strap         (topo_q)
   );

   // Strap fields go out straight from the capture flops
   assign ramp_enable                  = topo_q[`BFS_TOPO_RAMP];
   assign ramp_scale_bits              = freq_q[2:1];
   assign freq_select                  = freq_q[4:3];
   assign forced_continuous_conduction = freq_q[`BFS_FREQ_FORCED_CONTINUOUS_CONDUCTION];
   assign fault_policy_bit             = ref_q[`BFS_REF_POLICY];
   assign soft_start_select            = topo_q[1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Length lookups
   function automatic bfs_cnt_t ss_len(input logic [1:0] sel);
      ss_len = bfs_cnt_t'(SS_CYC) << sel;
   endfunction

   function automatic bfs_cnt_t hic_len(input logic [1:0] sel);
      logic [47:0] p;
      p = 48'(HIC_CYC);
      case (sel)
         2'h0:    p = p * 48'(`BFS_HIC_MUL_1MS);
         2'h1:    p = p * 48'(`BFS_HIC_MUL_2MS);
         2'h2:    p = p * 48'(`BFS_HIC_MUL_4MS);
         default: p = p * 48'(`BFS_HIC_MUL_8MS);
      endcase
      hic_len = p[23:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Supervisor state
   bfs_sup_s r_reg;
   bfs_sup_s r_next;
   logic     uv_done;
   logic     ss_done;
   logic     go;
   logic     latch_pol;

   assign uv_done   = uv_s && (r_reg.uvc == bfs_cnt_t'(UV_CYC - 1));
   assign ss_done   = r_reg.ext_ss ? extss_s
                      : (r_reg.cnt >= ss_len(topo_q[1:0]) - 24'h000001);
   assign go        = bias_ok_s && en_s && !ot_s && straps_valid;
   assign latch_pol = ref_q[`BFS_REF_POLICY];

   // Next state, driver enables and status
   always_comb begin
      r_next         = r_reg;
      r_next.ext_ref = topo_q[`BFS_TOPO_EXTREF];
      r_next.ext_ss  = !topo_q[`BFS_TOPO_EXTREF] && topo_q[`BFS_TOPO_EXTSS];
      // Filter counts only while the guard is armed
      if ((r_reg.st == BFS_RUN || r_reg.st == BFS_DISCH) && uv_s) begin
         r_next.uvc = r_reg.uvc + 24'h000001;
      end else begin
         r_next.uvc = `BFS_CNT_RST;
      end
      case (r_reg.st)
         BFS_OFF: begin
            r_next.cnt = `BFS_CNT_RST;
            if (go) begin
               r_next.st = BFS_SOFT;
            end
         end
         BFS_SOFT: begin
            r_next.cnt = r_reg.cnt + 24'h000001;
            if (ov_s) begin
               r_next.st = BFS_DISCH;
            end else if (ss_done) begin
               r_next.st = BFS_RUN;
            end
         end
         BFS_RUN: begin
            if (ov_s) begin
               r_next.st = BFS_DISCH;
            end else if (uv_done) begin
               r_next.st  = latch_pol ? BFS_LATCH : BFS_HICCUP;
               // RUN keeps the soft-start tally, so blanking must start from zero
               r_next.cnt = `BFS_CNT_RST;
            end
         end
         BFS_DISCH: begin
            r_next.cnt = r_reg.cnt + 24'h000001;
            if (uv_done) begin
               // Internal mode always latches; external modes obey policy
               if ((!r_reg.ext_ref && !r_reg.ext_ss) || latch_pol) begin
                  r_next.st = BFS_LATCH_LS;
               end else begin
                  r_next.st  = BFS_HICCUP;
                  r_next.cnt = `BFS_CNT_RST;
               end
            end
         end
         BFS_HICCUP: begin
            r_next.cnt = r_reg.cnt + 24'h000001;
            if (r_reg.cnt >= hic_len(topo_q[1:0]) - 24'h000001) begin
               r_next.st  = BFS_SOFT;
               r_next.cnt = `BFS_CNT_RST;
            end
         end
         BFS_LATCH, BFS_LATCH_LS: begin
            r_next.cnt = `BFS_CNT_RST;
         end
         default: begin
            r_next.st = BFS_OFF;
         end
      endcase
      // Overrides: lockout, then enable, then temperature
      if (!bias_ok_s || !en_s) begin
         r_next.st = BFS_OFF;
      end else if (ot_s) begin
         // Temperature never clears a latched fault
         if (r_reg.st == BFS_LATCH || r_reg.st == BFS_LATCH_LS) begin
            r_next.st = BFS_LATCH;
         end else begin
            r_next.st = BFS_OFF;
         end
      end
      // Driver enables follow the next state
      case (r_next.st)
         BFS_SOFT, BFS_RUN: begin
            // Once off, stay off while valley current is above the limit
            r_next.hs = onreq_s && (r_reg.hs || !valley_s);
            r_next.ls = !r_next.hs;
         end
         BFS_DISCH: begin
            if (r_reg.st != BFS_DISCH) begin
               r_next.hs  = 1'b0;
               r_next.ls  = 1'b1;
               r_next.cnt = `BFS_CNT_RST;
            end else if (r_reg.ls) begin
               r_next.hs  = neg_s;
               r_next.ls  = !neg_s;
               r_next.cnt = `BFS_CNT_RST;
            end else if (r_reg.cnt >= bfs_cnt_t'(MIN_ON_CYC - 1)) begin
               r_next.hs = 1'b0;
               r_next.ls = 1'b1;
            end
         end
         BFS_LATCH_LS: begin
            r_next.hs = 1'b0;
            r_next.ls = 1'b1;
         end
         default: begin
            r_next.hs = 1'b0;
            r_next.ls = 1'b0;
         end
      endcase
      r_next.ovfix = r_next.ext_ref && (r_next.st == BFS_SOFT);
      r_next.flt   = (r_next.st == BFS_LATCH) || (r_next.st == BFS_LATCH_LS);
      r_next.ssact = (r_next.st == BFS_SOFT);
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         r_reg <= '{st: BFS_OFF, cnt: `BFS_CNT_RST, uvc: `BFS_CNT_RST, default: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign hs_enable           = r_reg.hs;
   assign ls_enable           = r_reg.ls;
   assign fault_latched       = r_reg.flt;
   assign soft_start_active   = r_reg.ssact;
   assign ovp_fixed_threshold = r_reg.ovfix;
   assign use_ext_reference   = r_reg.ext_ref;
   assign ext_soft_start      = r_reg.ext_ss;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_neg_hit;
      r_reg.st == BFS_DISCH && r_reg.ls && neg_s && bias_ok_s && en_s && !ot_s && !uv_done;
   endsequence
   sequence s_min_on;
      hs_enable && !ls_enable;
   endsequence

   a_lockout_off: assert property (!bias_ok_s |=> !hs_enable && !ls_enable && r_reg.st == BFS_OFF)
      else $error("drivers active under supply lockout");
   a_lockout_resume: assert property (r_reg.st == BFS_OFF && go |=> r_reg.st == BFS_SOFT)
      else $error("no restart after lockout cleared");
   a_strap_bias: assert property ($rose(straps_valid) |-> $past(bias_ok_s))
      else $error("straps captured without bias");
   a_strap_hold: assert property (straps_valid && $past(straps_valid) |-> $stable(topo_q) && $stable(freq_q) && $stable(ref_q))
      else $error("strap settings changed");
   a_valley_hold: assert property (r_reg.st == BFS_RUN && !hs_enable && valley_s |=> !hs_enable)
      else $error("turn-on during valley over-limit");
   a_uv_trip: assert property (r_reg.st == BFS_RUN && uv_done && !ov_s && go |=> !hs_enable && !ls_enable && (fault_latched == latch_pol))
      else $error("undervoltage did not shut drivers");
   a_uv_unarmed: assert property (r_reg.st == BFS_SOFT && go && !ov_s |=> r_reg.st inside {BFS_SOFT, BFS_RUN})
      else $error("undervoltage acted before soft-start end");
   a_ov_entry: assert property (r_reg.st == BFS_RUN && ov_s && go |=> !hs_enable && ls_enable && r_reg.st == BFS_DISCH)
      else $error("overvoltage did not start discharge");
   a_neg_cycle: assert property (s_neg_hit |=> s_min_on ##1 ((hs_enable && !ls_enable) || r_reg.st != BFS_DISCH))
      else $error("no minimum on-time after negative limit");
   a_latch_ls: assert property (r_reg.st == BFS_LATCH_LS |-> !hs_enable && ls_enable && fault_latched)
      else $error("low side not latched on");
   a_clear_en: assert property (fault_latched && !en_s |=> !fault_latched)
      else $error("latched fault not cleared by enable");
   a_temp_off: assert property (ot_s |=> !hs_enable && !ls_enable)
      else $error("drivers active while hot");
   a_fixed_ovp: assert property (ovp_fixed_threshold |-> use_ext_reference && soft_start_active)
      else $error("fixed overvoltage level outside startup");
endmodule

// ==== bfs_stage_model.sv ====
// Power stage stand-in: low-side current ramp and negative limit comparator
`timescale 1ns/1ps
module bfs_stage_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic ls_enable,
   input  wire logic slow,
   output logic      neg_limit
);
   logic [3:0] ls_cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Current falls while the low side conducts; saturate so it never wraps
   always_ff @(posedge clock) begin
      if (rst || !ls_enable) begin
         ls_cnt_reg <= 4'h0;
      end else if (ls_cnt_reg != 4'hF) begin
         ls_cnt_reg <= ls_cnt_reg + 4'h1;
      end
   end

   // Trips once enough reverse current builds; drops when the low side opens
   assign neg_limit = ls_cnt_reg >= (slow ? 4'h8 : 4'h3);
endmodule

// ==== bfs_supervisor_tb_top.sv ====
// Self-checking bench for the fault and enable supervisor
`timescale 1ns/1ps
module bfs_supervisor_tb_top;
   localparam int SS = 16;
   localparam int UVC = 20;
   localparam int HIC = 4;
   localparam int MIN_ON = 2;

   logic        clock = 1'b0, rst = 1'b1, supply_lockout = 1'b1, bias_collapse = 1'b0;
   logic        enable_threshold_input = 1'b0, uv_cmp = 1'b0, ov_cmp = 1'b0;
   logic        valley_over_limit = 1'b0, over_temp = 1'b0, on_request = 1'b0;
   logic        ext_ss_done = 1'b0, slow = 1'b0, neg_limit;
   logic [4:0]  freq_strap_pin = 5'h00, ref_strap_pin = 5'h00, topo_strap_pin = 5'h00;
   logic        hs_enable, ls_enable, fault_latched, soft_start_active, ovp_fixed_threshold;
   logic        use_ext_reference, ext_soft_start, ramp_enable, forced_continuous_conduction;
   logic        fault_policy_bit, straps_valid;
   logic [1:0]  ramp_scale_bits, freq_select, soft_start_select;
   int          mismatches = 0, cmp_count = 0, cycles = 0, n;
   wire  [10:0] flds = {ramp_enable, ramp_scale_bits, freq_select, forced_continuous_conduction,
                        fault_policy_bit, soft_start_select, use_ext_reference, ext_soft_start};

   // Strap pins {freq, ref, topo} beside the decoded fields they should give
   logic [14:0] pins [4] = '{{5'h04, 5'h1E, 5'h07}, {5'h12, 5'h00, 5'h1A},
                             {5'h09, 5'h11, 5'h0D}, {5'h1B, 5'h01, 5'h10}};
   logic [10:0] exp_f [4] = '{{1'h0, 2'h2, 2'h0, 1'h0, 1'h0, 2'h3, 1'h0, 1'h1},
                              {1'h1, 2'h1, 2'h2, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0},
                              {1'h0, 2'h0, 2'h1, 1'h1, 1'h1, 2'h1, 1'h1, 1'h0},
                              {1'h1, 2'h1, 2'h3, 1'h1, 1'h1, 2'h0, 1'h0, 1'h0}};

   bfs_supervisor #(.UV_CYC(UVC), .SS_CYC(SS), .HIC_CYC(HIC), .MIN_ON_CYC(MIN_ON))
      u_bfs_supervisor (.*);
   bfs_stage_model u_bfs_stage_model (.*);

   ////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the ceiling leaves ample room over the whole run
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic step(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Collapse the bias, present new straps, then bring the bias back
   task automatic strap_cycle(input int i);
      {freq_strap_pin, ref_strap_pin, topo_strap_pin} <= pins[i];
      supply_lockout <= 1'b1;
      bias_collapse <= 1'b1;
      step(5);
      chk("straps_valid in lockout", 1'b0, straps_valid);
      supply_lockout <= 1'b0;
      bias_collapse <= 1'b0;
      step(5);
   endtask

   // Length of the soft-start now starting or under way, bounded both ways
   task automatic ss_len(output int k);
      k = 0;
      while (soft_start_active !== 1'b1 && k < 20) begin
         step(1);
         k++;
      end
      k = 0;
      while (soft_start_active === 1'b1 && k < 400) begin
         step(1);
         k++;
      end
   endtask

   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: strap rows first, then the fault cases by hand
   initial begin
      step(4);
      rst <= 1'b0;
      on_request <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         strap_cycle(i);
         chk("straps_valid", 1'b1, straps_valid);
         chk("strap fields", exp_f[i], flds);
      end
      // Lockout wins over enable and clears itself
      supply_lockout <= 1'b1;
      enable_threshold_input <= 1'b1;
      step(8);
      chk("drivers in lockout", 3'h0, {soft_start_active, hs_enable, ls_enable});
      uv_cmp <= 1'b1;
      supply_lockout <= 1'b0;
      {freq_strap_pin, ref_strap_pin, topo_strap_pin} <= pins[0];
      ss_len(n);
      chk("soft-start length", 1'b1, n >= SS && n <= SS + 2);
      // Undervoltage held since start: only the run time may count
      step(15);
      chk("uv early", 1'b0, fault_latched);
      step(10);
      chk("uv latch", 3'h4, {fault_latched, hs_enable, ls_enable});
      enable_threshold_input <= 1'b0;
      uv_cmp <= 1'b0;
      step(5);
      chk("fault cleared", 1'b0, fault_latched);
      enable_threshold_input <= 1'b1;
      ss_len(n);
      chk("strap hold", exp_f[3], flds);
      // Valley over-limit keeps the high side off
      on_request <= 1'b0;
      step(4);
      chk("off state", 2'h1, {hs_enable, ls_enable});
      on_request <= 1'b1;
      valley_over_limit <= 1'b1;
      step(6);
      chk("valley hold", 2'h1, {hs_enable, ls_enable});
      valley_over_limit <= 1'b0;
      step(4);
      chk("valley release", 2'h2, {hs_enable, ls_enable});
      // Overvoltage discharge cycles, then latches the low side on
      ov_cmp <= 1'b1;
      step(4);
      chk("ov entry", 2'h1, {hs_enable, ls_enable});
      n = 0;
      while (hs_enable !== 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      n = 0;
      while (hs_enable === 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      chk("min on-time", 11'(MIN_ON), 11'(n));
      ov_cmp <= 1'b0;
      uv_cmp <= 1'b1;
      step(30);
      chk("discharge latch", 3'h5, {fault_latched, hs_enable, ls_enable});
      // Over-temperature shuts down and restarts unaided
      enable_threshold_input <= 1'b0;
      uv_cmp <= 1'b0;
      step(4);
      enable_threshold_input <= 1'b1;
      ss_len(n);
      over_temp <= 1'b1;
      step(4);
      chk("thermal off", 3'h0, {soft_start_active, hs_enable, ls_enable});
      over_temp <= 1'b0;
      step(5);
      chk("thermal restart", 1'b1, soft_start_active);
      // External reference with hiccup policy
      strap_cycle(1);
      step(3);
      chk("fixed ov level", 1'b1, ovp_fixed_threshold);
      ss_len(n);
      uv_cmp <= 1'b1;
      n = 0;
      while (hs_enable === 1'b1 && n < 40) begin
         step(1);
         n++;
      end
      uv_cmp <= 1'b0;
      chk("hiccup no latch", 1'b0, fault_latched);
      n = 0;
      while (soft_start_active !== 1'b1 && n < 300) begin
         step(1);
         n++;
      end
      chk("hiccup blank", 1'b1, n >= HIC * 38 && n <= HIC * 38 + 4);
      // External soft-start waits for its done input, not the internal timer
      strap_cycle(0);
      step(140);
      chk("ext ss wait", 1'b1, soft_start_active);
      ext_ss_done <= 1'b1;
      step(4);
      chk("ext ss done", 1'b0, soft_start_active);
      stop_test();
   end
endmodule
